/* File: core/e1_port_pkg.sv */
// Purpose: Shared constants and carriers of the E1 system-side port.
// Assumes: 32-bit AXI4-Lite register bus, aclk at 20 MHz.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package e1_port_pkg;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] INT_STAT_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] INT_MASK_OFS = 5'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control word, bit 0 is dual_rail
  typedef struct packed {
    logic hw_mode;
    logic alarm_indication_enable;
    logic recovery_bypass;
    logic rx_invert;
    logic rx_fall;
    logic tx_fall;
    logic hdb3;
    logic dual_rail;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = 8'h02;
  // Interrupt bit positions, shared by status and mask
  localparam int INT_W = 3;
  localparam int INT_TXCLK = 0;
  localparam int INT_CV = 1;
  localparam int INT_LOS = 2;
  localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;
  // Pins sampled from outside the aclk domain
  typedef struct packed {
    logic tx_clk;
    logic tx_sd;
    logic tx_p;
    logic tx_n;
    logic ref_clk;
    logic rx_p;
    logic rx_n;
    logic los;
  } pins_t;
  // Reference cycles of a frozen tx clock before it counts as lost
  localparam logic [6:0] TXCLK_MISS_REF = 7'h46;
  localparam longint ACLK_HZ = 64'h1312d00;
  localparam longint RCLK_HZ = 64'h1f4000;
  localparam int NCO_W = 16;
  localparam logic [NCO_W-1:0] NCO_INC =
    NCO_W'((RCLK_HZ << NCO_W) / ACLK_HZ);
  localparam logic [NCO_W-1:0] PHASE_ALIGN = 16'h1000;
  localparam logic [4:0] ZERO_RUN_HDB3 = 5'h04;
  localparam logic [4:0] ZERO_RUN_AMI = 5'h10;
endpackage

/* File: core/e1_port.sv */
// Purpose: System-side digital port of a single E1 line interface.
// Assumes: All pin inputs are asynchronous to aclk; slicer rails are RZ.
// Notes: Link clocks are sampled by aclk, so edges jitter by one cycle.
// Summary of operation
// RULE_01 - Tx data rails are captured on the chosen edge of the tx clock.
// RULE_02 - Tx clock frozen over 70 reference cycles is declared missing.
// RULE_03 - A missing tx clock raises an interrupt to the host.
// RULE_04 - Single rail: received NRZ data appears on one output.
// RULE_05 - Single-rail data is decoded with AMI or HDB3 rules as selected.
// RULE_06 - Each violation holds the violation flag high one receive clock.
// RULE_07 - HDB3 reports code violations, AMI reports bipolar violations.
// RULE_08 - In hardware mode the flag also reports excess zero errors.
// RULE_09 - Dual rail: retimed NRZ with recovery, raw RZ when bypassed.
// RULE_10 - Rx data launch on selectable rclk edge, with selectable polarity.
// RULE_11 - Receive clock runs at nominal 2.048 MHz.
// RULE_12 - Under loss of signal with alarm enable, rclk follows ref clock.
// RULE_13 - In recovery mode rclk is the clock recovered from the line.
// RULE_14 - With recovery bypassed rclk is the XOR of the slicer rails.
// RULE_15 - Tx rails: 00 and 11 space, 01 positive, 10 negative pulse.
// RULE_16 - System supplies the 2.048 MHz reference master clock.
// RULE_17 - Missing tx clock clears itself when transitions resume.
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
module e1_port
  import e1_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [e1_port_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [e1_port_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic tx_line_clock,
  input wire logic tx_single_rail_data,
  input wire logic tx_positive_rail,
  input wire logic tx_negative_rail,
  input wire logic ref_master_clock,
  input wire logic rx_slice_pos,
  input wire logic rx_slice_neg,
  input wire logic no_input_signal,
  output logic tx_symbol_pos,
  output logic tx_symbol_neg,
  output logic tx_symbol_valid,
  output logic rx_clock,
  output logic rx_positive_rail,
  output logic rx_negative_rail,
  output logic code_violation_flag,
  output logic irq
);
  pins_t pins, s1_q, s2_q, s3_q;
  ctrl_t ctrl_q;
  logic [INT_W-1:0] int_stat_q, int_mask_q, events;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [6:0] miss_cnt_q;
  logic tx_clk_missing_q, tx_edge, tx_chg, ref_rise, miss_set;
  logic [NCO_W-1:0] phase_q;
  logic rclk_d, rclk_rise, launch, pulse_edge, ref_fallback;
  logic seen_p_q, seen_n_q, cur_p, cur_n, mark, viol, code_viol;
  logic excess_zero_error;
  logic last_pol_q, sym_p_q, sym_n_q, flag_q, flag_event, los_q;
  logic [3:0] dly_q;
  logic [4:0] zrun_q;
  logic wr_go, ar_fire;

  // Register decode, shared by write and read paths
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    case (a)
      CTRL_OFS: reg_sel = 3'h0;
      STAT_OFS: reg_sel = 3'h1;
      INT_STAT_OFS: reg_sel = 3'h2;
      INT_MASK_OFS: reg_sel = 3'h3;
      default: reg_sel = 3'h7;
    endcase
  endfunction

  // Two-flop synchronisers; s3 only feeds edge detection
  assign pins = '{tx_line_clock, tx_single_rail_data, tx_positive_rail,
    tx_negative_rail, ref_master_clock, rx_slice_pos, rx_slice_neg,
    no_input_signal};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edge events on the sampled link clocks and rx rails; reference fallback level
  assign tx_chg = s2_q.tx_clk ^ s3_q.tx_clk;
  assign tx_edge = tx_chg & (s2_q.tx_clk ^ ctrl_q.tx_fall);
  assign ref_rise = s2_q.ref_clk & ~s3_q.ref_clk;
  assign pulse_edge = (s2_q.rx_p & ~s3_q.rx_p) | (s2_q.rx_n & ~s3_q.rx_n);
  assign ref_fallback = s2_q.los & ctrl_q.alarm_indication_enable;

  // Tx capture; data passes the same two flops as the clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_symbol_pos <= 1'b0;
      tx_symbol_neg <= 1'b0;
      tx_symbol_valid <= 1'b0;
    end
    else
    begin
      tx_symbol_valid <= tx_edge; // [RULE_01]
      if (tx_edge && ctrl_q.dual_rail)
      begin
        tx_symbol_pos <= ~s2_q.tx_p & s2_q.tx_n; // [RULE_15]
        tx_symbol_neg <= s2_q.tx_p & ~s2_q.tx_n; // [RULE_15]
      end
      else if (tx_edge)
      begin
        tx_symbol_pos <= s2_q.tx_sd; // [RULE_01]
        tx_symbol_neg <= 1'b0;
      end
    end
  end

  // Tx clock watchdog counted in reference clock periods
  // Only the declaring edge counts, so a read can clear the status bit
  assign miss_set = ref_rise && !tx_chg && !tx_clk_missing_q &&
    miss_cnt_q == TXCLK_MISS_REF;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      miss_cnt_q <= '0;
      tx_clk_missing_q <= 1'b0;
    end
    else if (tx_chg)
    begin
      miss_cnt_q <= '0;
      tx_clk_missing_q <= 1'b0; // [RULE_17]
    end
    else if (ref_rise && !tx_clk_missing_q)
    begin
      miss_cnt_q <= miss_cnt_q + 7'h01;
      if (miss_set)
        tx_clk_missing_q <= 1'b1; // [RULE_02]
    end
  end

  // Receive clock source; loss with alarm enable takes priority
  always_comb
  begin
    if (ref_fallback)
      rclk_d = s2_q.ref_clk; // [RULE_12]
    else if (ctrl_q.recovery_bypass)
      rclk_d = s2_q.rx_p ^ s2_q.rx_n; // [RULE_14]
    else
      rclk_d = phase_q[NCO_W-1]; // [RULE_13]
  end
  assign rclk_rise = rclk_d & ~rx_clock;
  assign launch = (rclk_d ^ rx_clock) & (rclk_d ^ ctrl_q.rx_fall);

  // NCO recovery; pulses pull the phase, free run keeps the rate
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_q <= '0;
      rx_clock <= 1'b0;
    end
    else
    begin
      phase_q <= pulse_edge ? PHASE_ALIGN : phase_q + NCO_INC; // [RULE_11]
      rx_clock <= rclk_d;
    end
  end

  // Symbol of the current bit and decoder terms
  assign cur_p = seen_p_q | s2_q.rx_p;
  assign cur_n = seen_n_q | s2_q.rx_n;
  assign mark = cur_p | cur_n;
  assign viol = mark & ~(cur_p ^ last_pol_q);
  assign code_viol = viol & (!ctrl_q.hdb3 || dly_q[1:0] != 2'h0); // [RULE_07]
  assign excess_zero_error = !mark && zrun_q ==
    (ctrl_q.hdb3 ? ZERO_RUN_HDB3 : ZERO_RUN_AMI) - 5'h01;
  assign flag_event = code_viol |
    (ctrl_q.hw_mode & excess_zero_error); // [RULE_08]

  // Decoder, advanced once per receive clock rising edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {seen_p_q, seen_n_q, sym_p_q, sym_n_q, flag_q} <= '0;
      last_pol_q <= 1'b0;
      dly_q <= '0;
      zrun_q <= '0;
    end
    else if (rclk_rise)
    begin
      {seen_p_q, seen_n_q} <= 2'h0;
      {sym_p_q, sym_n_q} <= {cur_p, cur_n};
      flag_q <= flag_event; // [RULE_06]
      if (mark)
        last_pol_q <= cur_p;
      zrun_q <= mark ? 5'h00 : (zrun_q == 5'h1f ? zrun_q : zrun_q + 5'h01);
      if (ctrl_q.hdb3 && viol && dly_q[1:0] == 2'h0)
        dly_q <= 4'h0; // [RULE_05]
      else
        dly_q <= {dly_q[2:0], mark}; // [RULE_05]
    end
    else
    begin
      seen_p_q <= cur_p;
      seen_n_q <= cur_n;
    end
  end

  // Output launch on the chosen rclk edge; raw dual-rail bypass data passes on
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_positive_rail <= 1'b0;
      rx_negative_rail <= 1'b0;
      code_violation_flag <= 1'b0;
    end
    else if (ctrl_q.dual_rail && ctrl_q.recovery_bypass)
    begin
      rx_positive_rail <= s2_q.rx_p ^ ctrl_q.rx_invert; // [RULE_09]
      rx_negative_rail <= s2_q.rx_n ^ ctrl_q.rx_invert; // [RULE_09]
      code_violation_flag <= 1'b0;
    end
    else if (launch && ctrl_q.dual_rail)
    begin
      rx_positive_rail <= sym_p_q ^ ctrl_q.rx_invert; // [RULE_09] [RULE_10]
      rx_negative_rail <= sym_n_q ^ ctrl_q.rx_invert; // [RULE_09] [RULE_10]
      code_violation_flag <= 1'b0;
    end
    else if (launch)
    begin
      rx_positive_rail <= dly_q[3] ^ ctrl_q.rx_invert; // [RULE_04] [RULE_10]
      rx_negative_rail <= 1'b0;
      code_violation_flag <= flag_q; // [RULE_06]
    end
  end

  // Sticky events; a set in the clearing read cycle survives
  assign events = {s2_q.los & ~los_q, flag_event & rclk_rise, miss_set};
  assign ar_fire = arvalid & arready;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_stat_q <= '0;
      los_q <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      los_q <= s2_q.los;
      int_stat_q <= (ar_fire && reg_sel(araddr) == 3'h2 ? '0 : int_stat_q)
        | events; // [RULE_03]
      irq <= |(int_stat_q & int_mask_q); // [RULE_03]
    end
  end

  // AXI4-Lite write: address and data in either order, then response
  assign wr_go = !awready && !wready && !bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        waddr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go)
      begin
        bvalid <= 1'b1;
        bresp <= reg_sel(waddr_q) == 3'h7 ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Writable registers; only byte lane 0 holds live bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= CTRL_RST;
      int_mask_q <= INT_MASK_RST;
    end
    else if (wr_go && wstrb_q[0])
    begin
      if (reg_sel(waddr_q) == 3'h0)
        ctrl_q <= wdata_q[7:0];
      if (reg_sel(waddr_q) == 3'h3)
        int_mask_q <= wdata_q[INT_W-1:0];
    end
  end

  // AXI4-Lite read, answered one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      case (reg_sel(araddr))
        3'h0: rdata <= {24'h000000, ctrl_q};
        3'h1: rdata <= {30'h00000000, s2_q.los, tx_clk_missing_q};
        3'h2: rdata <= {29'h00000000, int_stat_q};
        3'h3: rdata <= {29'h00000000, int_mask_q};
        default:
        begin
          rdata <= '0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_pos_pair;
    tx_edge && ctrl_q.dual_rail && !s2_q.tx_p && s2_q.tx_n;
  endsequence
  sequence s_hdb3_sub;
    rclk_rise && ctrl_q.hdb3 && viol && dly_q[1:0] == 2'h0;
  endsequence
  property p_tx_pos;
    s_pos_pair |=> tx_symbol_pos && !tx_symbol_neg && tx_symbol_valid;
  endproperty
  a_tx_pos: assert property (p_tx_pos) // [RULE_15] [RULE_01]
    else $error("positive rail pair not captured");
  property p_miss;
    ref_rise && !tx_chg && !tx_clk_missing_q && miss_cnt_q == TXCLK_MISS_REF
      |=> tx_clk_missing_q;
  endproperty
  a_miss: assert property (p_miss) // [RULE_02]
    else $error("tx clock loss not declared");
  property p_miss_int;
    $rose(tx_clk_missing_q) |-> int_stat_q[INT_TXCLK];
  endproperty
  a_miss_int: assert property (p_miss_int) // [RULE_03]
    else $error("tx clock loss did not set interrupt status");
  property p_miss_clr;
    tx_clk_missing_q && tx_chg |=> !tx_clk_missing_q;
  endproperty
  a_miss_clr: assert property (p_miss_clr) // [RULE_17]
    else $error("tx clock loss did not clear");
  property p_sub;
    s_hdb3_sub |=> dly_q == 4'h0;
  endproperty
  a_sub: assert property (p_sub) // [RULE_05]
    else $error("substitution not removed");
  property p_cv_hold;
    $changed(code_violation_flag) |-> $past(launch) || $past(ctrl_q.dual_rail);
  endproperty
  a_cv_hold: assert property (p_cv_hold) // [RULE_06]
    else $error("violation flag moved between receive clock edges");
  property p_ami_viol;
    rclk_rise && !ctrl_q.hdb3 && viol |=> flag_q;
  endproperty
  a_ami_viol: assert property (p_ami_viol) // [RULE_07]
    else $error("bipolar violation not flagged");
  property p_hw_zeros;
    rclk_rise && ctrl_q.hw_mode && excess_zero_error |=> flag_q;
  endproperty
  a_hw_zeros: assert property (p_hw_zeros) // [RULE_08]
    else $error("excess zeros not flagged in hardware mode");
  property p_rclk_ref;
    ref_fallback |=> rx_clock == $past(s2_q.ref_clk);
  endproperty
  a_rclk_ref: assert property (p_rclk_ref) // [RULE_12]
    else $error("receive clock not taken from reference");
  property p_rclk_xor;
    !ref_fallback && ctrl_q.recovery_bypass
      |=> rx_clock == $past(s2_q.rx_p ^ s2_q.rx_n);
  endproperty
  a_rclk_xor: assert property (p_rclk_xor) // [RULE_14]
    else $error("receive clock is not rail XOR");
  property p_rclk_rec;
    !ref_fallback && !ctrl_q.recovery_bypass
      |=> rx_clock == $past(phase_q[NCO_W-1]);
  endproperty
  a_rclk_rec: assert property (p_rclk_rec) // [RULE_13]
    else $error("receive clock is not the recovered clock");
  property p_rd_single;
    launch && !ctrl_q.dual_rail
      |=> rx_positive_rail == $past(dly_q[3] ^ ctrl_q.rx_invert);
  endproperty
  a_rd_single: assert property (p_rd_single) // [RULE_04] [RULE_10]
    else $error("single rail data wrong at launch");
endmodule

/* File: dv/e1_far_side.sv */
// Purpose: Framer-side model that drives the link clocks and slicer rails of the E1 port.
// Assumes: Reference clock 2.048 MHz, tx line clock period 400 ns.
// Notes: Rx marks alternate unless the bench asks for a violation.
module e1_far_side
(
  input wire logic tx_run,
  input wire logic rx_on,
  input wire logic rx_bad,
  output logic tx_line_clock,
  output logic ref_master_clock,
  output logic rx_slice_pos,
  output logic rx_slice_neg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pol;
  // Free-running reference master clock
  initial
  begin
    ref_master_clock = 1'b0;
    forever #244 ref_master_clock = ~ref_master_clock;
  end
  // Tx clock freezes at its last level while stopped
  initial
  begin
    tx_line_clock = 1'b0;
    forever #200 if (tx_run) tx_line_clock = ~tx_line_clock;
  end
  // Rails start idle, no pulse before the first mark
  initial
  begin
    pol = 1'b0;
    rx_slice_pos = 1'b0;
    rx_slice_neg = 1'b0;
  end
  // One RZ mark per bit; a held polarity is a bipolar violation
  always @(posedge ref_master_clock)
  begin
    if (rx_on)
    begin
      if (!rx_bad) pol = ~pol;
      rx_slice_pos <= pol;
      rx_slice_neg <= ~pol;
    end
  end
  // Return to zero in the second half of the bit
  always @(negedge ref_master_clock)
  begin
    rx_slice_pos <= 1'b0;
    rx_slice_neg <= 1'b0;
  end
endmodule

/* File: dv/e1_port_tb_top.sv */
// Purpose: Self-checking bench of the E1 system-side port.
// Assumes: Far-side model makes the link clocks and slicer pulses.
// Notes: Rates are compared by counting edges over 2000 aclk cycles.
module e1_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import e1_port_pkg::*;
  // Row fields: ctrl, then sd, p, n, expected pos, expected neg
  typedef struct packed {
    logic [7:0] ctrl;
    logic sd, p, n, ep, en;
  } row_t;
  row_t rows [6] = '{{8'h02, 5'h12}, {8'h02, 5'h00}, {8'h03, 5'h00},
    {8'h03, 5'h06}, {8'h03, 5'h09}, {8'h07, 5'h0c}};
  // HDB3 inverted, AMI, then hardware mode on falling edges
  logic [31:0] viol_ctrl [3] = '{32'h12, 32'h00, 32'h8a};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic tx_line_clock, tx_single_rail_data, tx_positive_rail;
  logic tx_negative_rail, ref_master_clock, rx_slice_pos, rx_slice_neg;
  logic no_input_signal, tx_symbol_pos, tx_symbol_neg, tx_symbol_valid;
  logic rx_clock, rx_positive_rail, rx_negative_rail;
  logic code_violation_flag, irq, tx_run, rx_on, rx_bad;
  int err_count, comparisons, w;

  e1_port dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .tx_line_clock,
    .tx_single_rail_data, .tx_positive_rail, .tx_negative_rail,
    .ref_master_clock, .rx_slice_pos, .rx_slice_neg, .no_input_signal,
    .tx_symbol_pos, .tx_symbol_neg, .tx_symbol_valid, .rx_clock,
    .rx_positive_rail, .rx_negative_rail, .code_violation_flag, .irq);
  e1_far_side far_u (.tx_run, .rx_on, .rx_bad, .tx_line_clock,
    .ref_master_clock, .rx_slice_pos, .rx_slice_neg);

  // Verdict and end of run, shared with every timeout
  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // A spent bound counts as a mismatch and ends the run
  task limit(input int n, input int lim);
    if (n >= lim)
    begin
      $display("ERROR wait_bound expected %0d seen %0d", lim - 1, n);
      err_count++;
      complete_run;
    end
  endtask
  // Write: AW and W released one by one as each is taken
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] v,
    input logic [1:0] er);
    int n;
    logic aw_p, w_p;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    n = 0;
    while ((aw_p || w_p) && n < 50)
    begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1 && aw_p)
      begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && w_p)
      begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    limit(n, 50);
    while (bvalid !== 1'b1 && n < 100)
    begin
      @(posedge aclk);
      n++;
    end
    limit(n, 100);
    bready <= 1'b0;
    check("bresp", er, bresp);
  endtask
  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] v,
    output logic [1:0] rr);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (arready !== 1'b1 && n < 50);
    limit(n, 50);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < 100)
    begin
      @(posedge aclk);
      n++;
    end
    limit(n, 100);
    v = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  function automatic logic sel(input int s);
    case (s)
      0: return tx_symbol_valid;
      1: return code_violation_flag;
      default: return irq;
    endcase
  endfunction
  task automatic wait_for(input int s, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (sel(s) !== 1'b1 && n < lim);
    limit(n, lim);
  endtask
  // Rx clock rises against reference rises; both near 2.048 MHz
  task automatic rate(input string nm, input int tol);
    int nr, nf;
    logic pr, pf;
    nr = 0;
    nf = 0;
    pr = rx_clock;
    pf = ref_master_clock;
    repeat (2000)
    begin
      @(posedge aclk);
      if (rx_clock === 1'b1 && pr === 1'b0) nr++;
      if (ref_master_clock && !pf) nf++;
      pr = rx_clock;
      pf = ref_master_clock;
    end
    check(nm, 32'h1, {31'h0, nr - nf <= tol && nf - nr <= tol && nr > 150});
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {tx_single_rail_data, tx_positive_rail, tx_negative_rail} = 3'h0;
    {no_input_signal, rx_on, rx_bad} = 3'h0;
    tx_run = 1'b1;
    err_count = 0;
    comparisons = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(CTRL_OFS, d, r);
    check("ctrl_reset", 32'h2, d);
    axi_rd(5'h10, d, r);
    check("unmapped_resp", RESP_SLVERR, r);
    axi_wr(5'h14, 32'h0, RESP_SLVERR);
    axi_wr(INT_MASK_OFS, 32'h1, RESP_OKAY);
    axi_rd(INT_MASK_OFS, d, r);
    check("int_mask", 32'h1, d);
    $display("test registers done");
    foreach (rows[i])
    begin
      axi_wr(CTRL_OFS, {24'h0, rows[i].ctrl}, RESP_OKAY);
      tx_single_rail_data <= rows[i].sd;
      tx_positive_rail <= rows[i].p;
      tx_negative_rail <= rows[i].n;
      wait_for(0, 40);
      @(posedge aclk);
      wait_for(0, 40);
      check("tx_pos", rows[i].ep, tx_symbol_pos);
      if (rows[i].ctrl[0])
        check("tx_neg", rows[i].en, tx_symbol_neg);
    end
    $display("test tx rows done");
    rx_on <= 1'b1;
    axi_wr(CTRL_OFS, 32'h21, RESP_OKAY);
    rate("bypass_xor_rate", 2);
    axi_wr(CTRL_OFS, 32'h02, RESP_OKAY);
    rate("recovered_rate", 3);
    rx_on <= 1'b0;
    no_input_signal <= 1'b1;
    axi_wr(CTRL_OFS, 32'h42, RESP_OKAY);
    rate("los_ref_rate", 2);
    no_input_signal <= 1'b0;
    $display("test rx clock done");
    foreach (viol_ctrl[k])
    begin
      rx_on <= 1'b1;
      axi_wr(CTRL_OFS, viol_ctrl[k], RESP_OKAY);
      repeat (200) @(posedge aclk);
      // Unbroken marks decode to steady ones at the chosen polarity
      check("rx_rd", 32'h1 ^ viol_ctrl[k][4], rx_positive_rail);
      check("rx_rdn", 32'h0, rx_negative_rail);
      axi_rd(INT_STAT_OFS, d, r);
      // Hardware mode row stops the marks to build an excess zero run
      if (viol_ctrl[k][7])
        rx_on <= 1'b0;
      else
        rx_bad <= 1'b1;
      @(posedge ref_master_clock);
      @(posedge aclk);
      rx_bad <= 1'b0;
      wait_for(1, 400);
      w = 0;
      while (code_violation_flag === 1'b1 && w < 30)
      begin
        @(posedge aclk);
        w++;
      end
      check("flag_width", 32'h1, {31'h0, w >= 8 && w <= 10});
      axi_rd(INT_STAT_OFS, d, r);
      check("flag_status", 32'h2, d & 32'h2);
    end
    $display("test violations done");
    axi_rd(INT_STAT_OFS, d, r);
    tx_run <= 1'b0;
    repeat (630) @(posedge aclk);
    axi_rd(STAT_OFS, d, r);
    check("tx_clk_early", 32'h0, d & 32'h1);
    check("irq_early", 32'h0, {31'h0, irq});
    wait_for(2, 150);
    axi_rd(STAT_OFS, d, r);
    check("tx_clk_missing", 32'h1, d & 32'h1);
    tx_run <= 1'b1;
    repeat (20) @(posedge aclk);
    axi_rd(STAT_OFS, d, r);
    check("tx_clk_back", 32'h0, d & 32'h1);
    $display("test tx clock loss done");
    complete_run;
  end
endmodule
